/* File: design/icc_defines.vh */
`ifndef ICC_DEFINES_VH
`define ICC_DEFINES_VH

// Register byte offsets, one aligned word per register
`define ICC_CTRL1_OFF   8'h00
`define ICC_CTRL2_OFF   8'h04
`define ICC_CTRL7_OFF   8'h08
`define ICC_CTRL8_OFF   8'h0C
`define ICC_FIFO1_OFF   8'h10
`define ICC_FIFO2_OFF   8'h14
`define ICC_FIFO7_OFF   8'h18
`define ICC_FIFO8_OFF   8'h1C
`define ICC_IRQ_STAT_OFF 8'h20
`define ICC_IRQ_MASK_OFF 8'h24

// Control register fields
`define ICC_MODE_LSB    0
`define ICC_MODE_MSB    2
`define ICC_TSEL_BIT    7
`define ICC_HAS_DATA_BIT 3
`define ICC_OVF_BIT     4
`define ICC_CTRL_RESET  3'h0
`define ICC_TSEL_RESET  1'b1

// Capture mode encodings
`define ICC_MODE_OFF    3'h0
`define ICC_MODE_BOTH   3'h1
`define ICC_MODE_FALL   3'h2
`define ICC_MODE_RISE   3'h3
`define ICC_MODE_RISE4  3'h4
`define ICC_MODE_RISE16 3'h5

// Prescale divide counts
`define ICC_DIV4_LAST   4'h3
`define ICC_DIV16_LAST  4'hF

`define ICC_FIFO_DEPTH  4

`endif

/* File: design/icc_input_capture.v */
// Operation
// RULE1 - Three-bit mode field selects fall, rise, every 4th/16th rise, or both edges.
// RULE2 - Prescaler settings come only from the mode field, no separate control.
// RULE3 - Edge prescaler counter clears when channel is off and on reset.
// RULE4 - Each channel owns a four-deep FIFO of 16-bit captures.
// RULE5 - Not-empty flag sets on first capture, holds until FIFO is drained.
// RULE6 - Each FIFO read returns oldest word and advances remaining words.
// RULE7 - Fifth capture into a full FIFO before a read sets overflow flag.
// RULE8 - On overflow the fifth value is dropped, stored entries untouched.
// RULE9 - After overflow, captures are ignored until all four entries are read.
// RULE10 - Software reads FIFO only while not-empty; empty reads are undefined.
// RULE11 - Control bit 7 selects time_base_a or time_base_b per channel.
// RULE12 - After reset the channels use time_base_b.
// RULE13 - In every-edge mode the interrupt flag sets on each rising and falling edge.
// RULE14 - In every-edge mode every capture interrupts; captures-per-interrupt is ignored.
// RULE15 - In every-edge mode overflow is never raised.
// RULE16 - Input capture events raise an interrupt request.
// RULE17 - Up to eight channel indices; this instance has channels 1, 2, 7, 8.
// RULE18 - Synchronised qualifying edge pushes selected 16-bit time base count.
// RULE19 - Reset clears FIFO, not-empty and overflow; overflow clears once drained.
`timescale 1ns/10ps
`default_nettype none
`include "icc_defines.vh"

module icc_input_capture #(
	parameter NCH   = 4,                    // Implemented channels [RULE17]
	parameter WIDTH = 16                    // Capture word width
) (
	input  wire             sys_clk,        // 10 MHz clock
	input  wire             rst_b,          // Async reset, active low
	input  wire [NCH-1:0]   captureIn,      // Inputs 1, 2, 7, 8 in bits 0..3
	input  wire [WIDTH-1:0] timeBaseA,      // time_base_a count
	input  wire [WIDTH-1:0] timeBaseB,      // time_base_b count
	input  wire [7:0]       s_axi_awaddr,   // Write address
	input  wire             s_axi_awvalid,  // Write address valid
	output reg              s_axi_awready,  // Write address ready
	input  wire [31:0]      s_axi_wdata,    // Write data
	input  wire [3:0]       s_axi_wstrb,    // Write strobes
	input  wire             s_axi_wvalid,   // Write data valid
	output reg              s_axi_wready,   // Write data ready
	output reg  [1:0]       s_axi_bresp,    // Write response
	output reg              s_axi_bvalid,   // Write response valid
	input  wire             s_axi_bready,   // Write response ready
	input  wire [7:0]       s_axi_araddr,   // Read address
	input  wire             s_axi_arvalid,  // Read address valid
	output reg              s_axi_arready,  // Read address ready
	output reg  [31:0]      s_axi_rdata,    // Read data
	output reg  [1:0]       s_axi_rresp,    // Read response
	output reg              s_axi_rvalid,   // Read data valid
	input  wire             s_axi_rready,   // Read data ready
	output reg              irq             // Level interrupt
);

	localparam DEPTH = `ICC_FIFO_DEPTH;

	// Write channel: address and data are taken independently
	reg            awHeld;
	reg            wHeld;
	reg  [7:0]     awAddr;
	reg  [31:0]    wData;
	reg  [3:0]     wStrb;
	reg  [NCH-1:0] wrCtrlHit;
	reg  [NCH-1:0] rdFifoHit;
	reg  [NCH-1:0] rdCtrlHit;
	reg            wrHit;
	reg            wrStat;
	reg            wrMask;
	wire           doWrite = awHeld && wHeld && !s_axi_bvalid;
	wire           doRead  = s_axi_arvalid && s_axi_arready;

	// Ready idles as a pulse, so a taken beat is never taken twice
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld        <= 1'b0;
			awAddr        <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !awHeld && !s_axi_awready;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld <= 1'b1;
				awAddr <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld <= 1'b0;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wHeld        <= 1'b0;
			wData        <= 32'h00000000;
			wStrb        <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !wHeld && !s_axi_wready;
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld <= 1'b1;
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld <= 1'b0;
			end
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrHit ? 2'h0 : 2'h2;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
		end
	end

	// Address decode
	integer k;
	always @* begin
		wrCtrlHit = {NCH{1'b0}};
		rdFifoHit = {NCH{1'b0}};
		rdCtrlHit = {NCH{1'b0}};
		for (k = 0; k < NCH; k = k + 1) begin
			if (awAddr == `ICC_CTRL1_OFF + 8'h04 * k[7:0]) begin
				wrCtrlHit[k] = 1'b1;
			end
			if (s_axi_araddr == `ICC_FIFO1_OFF + 8'h04 * k[7:0]) begin
				rdFifoHit[k] = 1'b1;
			end
			if (s_axi_araddr == `ICC_CTRL1_OFF + 8'h04 * k[7:0]) begin
				rdCtrlHit[k] = 1'b1;
			end
		end
		wrStat = awAddr == `ICC_IRQ_STAT_OFF;
		wrMask = awAddr == `ICC_IRQ_MASK_OFF;
		wrHit  = (|wrCtrlHit) || wrStat || wrMask;
	end

	// Per-channel state
	reg  [2:0]       mode [0:NCH-1];
	reg  [NCH-1:0]   tsel;
	reg  [NCH-1:0]   hasData;
	reg  [NCH-1:0]   ovf;
	reg  [NCH-1:0]   irqStat;
	reg  [NCH-1:0]   irqMask;
	reg  [WIDTH-1:0] fifo [0:NCH*DEPTH-1];
	reg  [2:0]       count [0:NCH-1];
	wire [NCH-1:0]   capEvent;
	wire [NCH-1:0]   popSel = doRead ? rdFifoHit : {NCH{1'b0}};

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : gCh
			reg              sync1;
			reg              sync2;
			reg              prev;
			reg  [3:0]       presc;
			reg              hit;
			reg              riseQual;
			reg  [3:0]       next_presc;
			reg  [2:0]       next_count;
			reg              next_hasData;
			reg              next_ovf;
			reg              next_irqStat;
			reg              doShift;
			reg              doStore;
			reg  [2:0]       storeIdx;
			wire             rise   = sync2 && !prev;
			wire             fall   = !sync2 && prev;
			wire             full   = count[g] == DEPTH;
			wire             empty  = count[g] == 3'h0;
			wire             both   = mode[g] == `ICC_MODE_BOTH;
			wire             pop    = popSel[g] && !empty;
			wire             push   = hit && !ovf[g] && !(full && both);
			wire             clrIrq = doWrite && wrStat && wStrb[0] && wData[g];
			wire [WIDTH-1:0] stamp  = tsel[g] ? timeBaseB : timeBaseA; // [RULE11]
			integer          j;

			// Control fields of this channel
			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					mode[g] <= `ICC_CTRL_RESET;
					tsel[g] <= `ICC_TSEL_RESET; // [RULE12]
				end else if (doWrite && wStrb[0] && wrCtrlHit[g]) begin
					mode[g] <= wData[`ICC_MODE_MSB:`ICC_MODE_LSB];
					tsel[g] <= wData[`ICC_TSEL_BIT];
				end
			end

			always @* begin
				riseQual = 1'b0;
				hit      = 1'b0;
				case (mode[g]) // [RULE1] [RULE2]
				`ICC_MODE_BOTH:   hit = rise || fall;
				`ICC_MODE_FALL:   hit = fall;
				`ICC_MODE_RISE:   hit = rise;
				`ICC_MODE_RISE4: begin
					riseQual = rise && presc[1:0] == `ICC_DIV4_LAST;
					hit      = riseQual;
				end
				`ICC_MODE_RISE16: begin
					riseQual = rise && presc == `ICC_DIV16_LAST;
					hit      = riseQual;
				end
				default:          hit = 1'b0;
				endcase
			end
			assign capEvent[g] = hit;

			// Prescaler advances on rises only; off mode parks it at zero
			always @* begin
				next_presc = presc;
				if (mode[g] == `ICC_MODE_OFF) begin
					next_presc = 4'h0; // [RULE3]
				end else if (rise) begin
					next_presc = presc + 4'h1;
				end
			end

			// A push in the same cycle as a pop lands behind the shift
			always @* begin
				next_count = count[g];
				doShift    = 1'b0;
				doStore    = 1'b0;
				storeIdx   = count[g];
				if (pop) begin
					doShift = 1'b1; // [RULE6]
					if (push) begin
						doStore  = 1'b1;
						storeIdx = count[g] - 3'h1;
					end else begin
						next_count = count[g] - 3'h1;
					end
				end else if (push && !full) begin
					doStore    = 1'b1; // [RULE4] [RULE18]
					next_count = count[g] + 3'h1;
				end
			end

			// Full and not popped: the fifth value has no slot [RULE8]
			always @* begin
				next_ovf = ovf[g];
				if (push && full && !pop) begin
					next_ovf = 1'b1; // [RULE7] [RULE9] [RULE15]
				end else if (pop && count[g] == 3'h1 && !push) begin
					next_ovf = 1'b0; // [RULE19]
				end
			end

			always @* begin
				next_hasData = hasData[g];
				if (push || (pop && count[g] > 3'h1)) begin
					next_hasData = 1'b1; // [RULE5]
				end else if (popSel[g]) begin
					next_hasData = 1'b0;
				end
			end

			// Each capture interrupts; set beats the clear
			always @* begin
				next_irqStat = irqStat[g];
				if (hit) begin
					next_irqStat = 1'b1; // [RULE13] [RULE14] [RULE16]
				end else if (clrIrq) begin
					next_irqStat = 1'b0;
				end
			end

			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					sync1      <= 1'b0;
					sync2      <= 1'b0;
					prev       <= 1'b0;
					presc      <= 4'h0; // [RULE3]
					count[g]   <= 3'h0; // [RULE19]
					hasData[g] <= 1'b0;
					ovf[g]     <= 1'b0;
					irqStat[g] <= 1'b0;
					for (j = 0; j < DEPTH; j = j + 1) begin
						fifo[g*DEPTH+j] <= {WIDTH{1'b0}};
					end
				end else begin
					sync1      <= captureIn[g];
					sync2      <= sync1;
					prev       <= sync2;
					presc      <= next_presc;
					count[g]   <= next_count;
					hasData[g] <= next_hasData;
					ovf[g]     <= next_ovf;
					irqStat[g] <= next_irqStat;
					if (doShift) begin
						for (j = 0; j < DEPTH - 1; j = j + 1) begin
							fifo[g*DEPTH+j] <= fifo[g*DEPTH+j+1];
						end
					end
					if (doStore) begin
						fifo[g*DEPTH+storeIdx] <= stamp;
					end
				end
			end
		end
	endgenerate

	// Interrupt mask register
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irqMask <= {NCH{1'b0}};
		end else if (doWrite && wStrb[0] && wrMask) begin
			irqMask <= wData[NCH-1:0];
		end
	end

	// Read data mux; FIFO reads pop the channel [RULE10]
	reg [31:0] rdNext;
	reg        rdOk;
	integer    r;
	always @* begin
		rdNext = 32'h00000000;
		rdOk   = 1'b0;
		for (r = 0; r < NCH; r = r + 1) begin
			if (rdCtrlHit[r]) begin
				rdOk = 1'b1;
				rdNext[`ICC_MODE_MSB:`ICC_MODE_LSB] = mode[r];
				rdNext[`ICC_HAS_DATA_BIT] = hasData[r];
				rdNext[`ICC_OVF_BIT]      = ovf[r];
				rdNext[`ICC_TSEL_BIT]     = tsel[r];
			end
			if (rdFifoHit[r]) begin
				rdOk = 1'b1;
				rdNext[WIDTH-1:0] = fifo[r*DEPTH];
			end
		end
		if (s_axi_araddr == `ICC_IRQ_STAT_OFF) begin
			rdOk = 1'b1;
			rdNext[NCH-1:0] = irqStat;
		end
		if (s_axi_araddr == `ICC_IRQ_MASK_OFF) begin
			rdOk = 1'b1;
			rdNext[NCH-1:0] = irqMask;
		end
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else begin
			if (doRead) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rdNext;
				s_axi_rresp  <= rdOk ? 2'h0 : 2'h2;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Interrupt line, one flop after status and mask
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStat & irqMask); // [RULE16]
		end
	end

endmodule
`default_nettype wire

/* File: testbench/icc_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module icc_checker (
	input wire logic        sys_clk,       // Clock
	input wire logic        rst_b,         // Reset
	input wire logic [7:0]  s_axi_araddr,  // Read address
	input wire logic        s_axi_arvalid, // Read valid
	input wire logic        s_axi_arready, // Read ready
	input wire logic [31:0] s_axi_rdata,   // Read data
	input wire logic [1:0]  s_axi_rresp,   // Read response
	input wire logic        s_axi_rvalid,  // Data valid
	input wire logic        s_axi_rready,  // Data ready
	input wire logic        s_axi_bvalid,  // Write response valid
	input wire logic        s_axi_bready   // Write response ready
);
	logic [7:0] ra;
	wire ctl = s_axi_rvalid && ra < 8'h10 && ra[1:0] == 2'h0;
	wire fifo = s_axi_rvalid && ra[7:4] == 4'h1 && ra[1:0] == 2'h0;
	wire bad = s_axi_rvalid && (ra > 8'h24 || ra[1:0] != 2'h0);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Address of the read in flight, to classify its answer
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ra <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready)
			ra <= s_axi_araddr;
	end
	word_width_a: assert property (fifo |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("capture word wider than 16 bits");
	ovf_has_data_a: assert property (ctl && s_axi_rdata[4] |-> s_axi_rdata[3])
		else $error("overflow without data");
	both_no_ovf_a: assert property (ctl && s_axi_rdata[2:0] == 3'h1 |-> !s_axi_rdata[4])
		else $error("overflow in every-edge mode");
	ctrl_fields_a: assert property (ctl |-> s_axi_rdata[31:8] == 0 && s_axi_rdata[6:5] == 0)
		else $error("control spare bits set");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	unmapped_a: assert property (bad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 0)
		else $error("unmapped read not refused");
	mapped_ok_a: assert property (s_axi_rvalid && !bad |-> s_axi_rresp == 2'h0)
		else $error("mapped read refused");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
endmodule
bind icc_input_capture icc_checker chk (.*);
`default_nettype wire

/* File: testbench/icc_sensor_model.sv */
`timescale 1ns/10ps
`default_nettype none
module icc_sensor_model (
	input wire logic       sys_clk,   // Clock
	output var logic [3:0] captureIn  // Sensor pins
);
	initial captureIn = 4'h0;
	// One edge per call; gap sets prompt or slow sensor
	task automatic flip(input int c, input int gap);
		repeat (gap) @(posedge sys_clk);
		captureIn[c] <= ~captureIn[c];
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        sys_clk, rst_b, irq;
	logic [3:0]  captureIn, s_axi_wstrb, mk;
	logic [15:0] timeBaseA, timeBaseB;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lfsr, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	int          bad_count = 0, checked = 0, cycles = 0;
	icc_input_capture uut (.*);
	icc_sensor_model sensor (.sys_clk(sys_clk), .captureIn(captureIn));
	initial begin
		sys_clk = 0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			bad_count++;
			give_verdict();
		end
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic hit(input logic [2:0] m, input logic up, input int pc);
		return m == 3'h1 || (m == 3'h2 && !up) || (m == 3'h3 && up)
			|| (up && m == 3'h4 && pc % 4 == 3) || (up && m == 3'h5 && pc % 16 == 15);
	endfunction
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task axr(input logic [7:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	task automatic run(input int c, input logic [2:0] m, input int n);
		logic [15:0] q[$];
		logic ts, ovf, up;
		int pc, ev;
		ts = lfsr[5];
		ovf = 0;
		pc = 0;
		ev = 0;
		mk = lfsr[11:8];
		axw(8'h24, {28'h0, mk});
		axw(8'(c * 4), 32'h0);
		axw(8'(c * 4), {24'h0, ts, 4'h0, m});
		repeat (n) begin
			lfsr = nxt(lfsr);
			@(posedge sys_clk);
			timeBaseA <= lfsr[15:0];
			timeBaseB <= lfsr[31:16];
			up = !captureIn[c];
			sensor.flip(c, 1 + lfsr[20] * 3);
			repeat (6) @(posedge sys_clk);
			if (hit(m, up, pc)) begin
				ev++;
				if (q.size() < 4 && !ovf) q.push_back(ts ? lfsr[31:16] : lfsr[15:0]);
				else if (m != 3'h1) ovf = 1;
			end
			pc += up;
		end
		axr(8'(c * 4));
		chk(d, {24'h0, ts, 2'h0, ovf, q.size() != 0, m});
		axr(8'h20);
		chk(d, 32'(ev != 0) << c);
		chk(irq, ev != 0 && mk[c]);
		axw(8'h20, 32'hF);
		while (q.size() != 0) begin
			axr(8'(8'h10 + c * 4));
			chk(d, q.pop_front());
		end
		axr(8'(c * 4));
		chk(d, {24'h0, ts, 4'h0, m});
		chk(irq, 0);
		$display("test done ch %0d mode %0d", c, m);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		rst_b = 0;
		lfsr = 32'hbf15;
		{timeBaseA, timeBaseB, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1;
		axr(8'h00);
		chk(d, 32'h80);
		axr(8'h30);
		chk(r, 2'h2);
		axw(8'h30, 32'h1);
		chk(r, 2'h2);
		run(0, 3'h2, 4);
		run(1, 3'h3, 12);
		run(2, 3'h1, 10);
		run(3, 3'h4, 16);
		run(0, 3'h5, 32);
		run(1, 3'h0, 4);
		repeat (6) begin
			lfsr = nxt(lfsr);
			run(lfsr[1:0], 3'(1 + lfsr[4:2] % 5), 1 + lfsr[9:6]);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
